// [include/oam_mip_defs.svh]
// Register map, field positions, reset values and encodings
`ifndef OAM_MIP_DEFS_SVH
`define OAM_MIP_DEFS_SVH
`define ADDR_ENTRY_SEL 8'h00
`define ADDR_VID_CTRL 8'h04
`define ADDR_DA_UPPER 8'h08
`define ADDR_DA_LOWER 8'h0C
`define ADDR_ENTRY_CFG 8'h10
`define ADDR_COPY_ONCE 8'h14
`define ADDR_GLOBAL 8'h18
`define ADDR_EVENTS 8'h1C
`define ADDR_ISDX_SEL 8'h20
`define ADDR_ROT_PTRS 8'h24
`define VID_MSB 11
`define SEL_LSB 12
`define SEL_MSB 13
`define CFG_LEVEL_MSB 2
`define CFG_ENA_LSB 3
`define CFG_ENA_MSB 7
`define CFG_OP_LSB 8
`define CFG_OP_MSB 15
`define CO_INTERVAL_MSB 1
`define CO_BIT 2
`define GL_ARM_BIT 0
`define GL_MASK_LSB 4
`define GL_MASK_MSB 7
`define PTR_FIELD_STRIDE 4
`define SEL_ANY 2'h0
`define SEL_UNTAGGED 2'h1
`define SEL_SINGLE 2'h2
`define SEL_BOTH 2'h3
`define ENA_CCM 0
`define ENA_LBM 1
`define ENA_LTM 2
`define ENA_RAPS 3
`define ENA_GEN 4
`define EV_CCM 0
`define EV_LBM 1
`define EV_LTM 2
`define EV_RAPS 3
`define EV_GEN 4
`define EV_DA_FAIL 5
`define EV_LEVEL_FAIL 6
`define EV_COUNT 7
`define NO_TAGS 3'h0
`define ONE_TAG 3'h1
`define ZERO_CLASS 3'h0
`define ONE_CLASS 3'h1
`define RD_ZERO 32'h0000_0000
`endif

// [include/oam_mip_pkg.sv]
// Types shared by the intermediate-point filter and class rotation
package oam_mip_pkg;
   typedef enum logic [2:0] {
      PDU_OTHER = 3'h0,
      PDU_CCM = 3'h1,
      PDU_LBM = 3'h2,
      PDU_LTM = 3'h3,
      PDU_RAPS = 3'h4,
      PDU_GENERIC = 3'h5
   } pdu_kind_type;
   typedef enum logic [1:0] {
      TS_NONE = 2'h0,
      TS_INJECT_LOOPBACK = 2'h1,
      TS_OTHER = 2'h2
   } timestamp_mode_field_type;
endpackage

// [logic/oam_mip_filter_cos_update.sv]
// Egress intermediate-point OAM filter and class-of-service rotation
//
// How it works
// R1 - Selector 0 accepts everything; selector 1 accepts only untagged frames.
// R2 - Selector 2 accepts single-tagged frames with matching VID only.
// R3 - Selector 3 accepts untagged or matching single-tagged frames.
// R4 - Loopback DA is upper 16 plus lower 32 bits; all-zero skips check.
// R5 - Sticky flag set when a continuity check is copied to CPU.
// R6 - Sticky flags for loopback and linktrace redirects to CPU.
// R7 - Sticky flags for ring protection and generic opcode handling.
// R8 - Sticky flag when a loopback fails the destination address check.
// R9 - Sticky flag when an enabled OAM frame fails the level check.
// R10 - Copy-once bit sends one continuity check to CPU, then clears.
// R11 - Arm-all sets copy-once where the entry's interval is in the mask.
// R12 - Injector marks inject-loopback and nonzero pointer selector.
// R13 - Class mask enables class ids; zero mask means no update.
// R14 - Four per-frame enables choose which class fields get rewritten.
// R15 - Rotate only when selector, service index and mask are nonzero.
// R16 - Scan offsets 0..7 from pointer; offset of first set mask bit is the class.
// R17 - Write (new class + 1) mod 8 back into the selected pointer.
// R18 - Up-facing frames get header and outer priority edits first pass.
// R19 - Up-facing first pass forces the pointer selector to zero.
// R20 - Down-facing frames ignore the outer-priority enable.
// R21 - Single tagged means exactly one known-protocol tag remains.
// R22 - Flags clear on write-one; a same-cycle event keeps them set.
`include "oam_mip_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module oam_mip_filter_cos_update #(
   parameter int ENTRIES = 128,
   parameter int ISDX_COUNT = 512,
   parameter int CLASSES = 8,
   parameter int EW = $clog2(ENTRIES),
   parameter int IW = $clog2(ISDX_COUNT)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Frame descriptor from the forwarding pipeline
   input wire logic frm_valid,
   input wire logic [EW-1:0] frm_entry,
   input wire oam_mip_pkg::pdu_kind_type frm_pdu,
   input wire logic [7:0] frm_opcode,
   input wire logic [2:0] frm_level,
   input wire logic [47:0] frm_da,
   input wire logic [1:0] frm_tags_in,
   input wire logic [1:0] frm_popped,
   input wire logic [1:0] frm_pushed,
   input wire logic frm_tag_known,
   input wire logic [11:0] frm_vid,
   input wire oam_mip_pkg::timestamp_mode_field_type frm_timestamp_mode_field,
   input wire logic [IW-1:0] frm_isdx,
   input wire logic [1:0] frm_nxt_sel,
   input wire logic [CLASSES-1:0] frm_class_mask,
   input wire logic frm_write_class_en,
   input wire logic frm_write_outer_prio_en,
   input wire logic frm_write_tc_en,
   input wire logic frm_write_stack_prio_en,
   input wire logic frm_up_mep,
   input wire logic [2:0] frm_class,
   input wire logic [2:0] frm_outer_prio,
   input wire logic [2:0] frm_tc,
   input wire logic [2:0] frm_stack_prio,
   // Edited descriptor to transmit path and CPU queues
   output logic out_valid,
   output logic out_mip_hit,
   output logic out_copy_cpu,
   output logic out_redirect_cpu,
   output logic [2:0] out_class,
   output logic [2:0] out_outer_prio,
   output logic [2:0] out_tc,
   output logic [2:0] out_stack_prio,
   output logic [1:0] out_nxt_sel
);

   // Per-entry table
   logic [11:0] required_outer_vid [ENTRIES];
   logic [1:0] outer_vid_match_select [ENTRIES];
   logic [15:0] da_hi [ENTRIES];
   logic [31:0] da_lo [ENTRIES];
   logic [2:0] level [ENTRIES];
   logic [4:0] ena [ENTRIES];
   logic [7:0] gen_op [ENTRIES];
   logic [1:0] interval [ENTRIES];
   logic [ENTRIES-1:0] copy_once;
   // Per service index pointers
   logic [2:0] cos_ptr [ISDX_COUNT][3];
   // Globals
   logic [EW-1:0] entry_sel;
   logic [IW-1:0] isdx_sel;
   logic [3:0] interval_mask;
   logic [`EV_COUNT-1:0] events;

   // First mask bit at or after the pointer, as an offset
   function automatic logic [2:0] pick_offset(input logic [7:0] mask,
                                              input logic [2:0] ptr);
      logic [2:0] res;
      logic found;
      res = `ZERO_CLASS;
      found = 1'b0;
      for (int i = 0; i < CLASSES; i++) begin
         if (!found && mask[3'(i + int'(ptr))]) begin
            res = 3'(i);
            found = 1'b1;
         end
      end
      return res;
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      return reg_wr && reg_addr == a;
   endfunction

   // Frame decision, combinational
   logic [2:0] remaining;
   logic single_tag, untagged, vid_ok, active, level_ok;
   logic da_check_off, da_ok;
   logic ccm_copy, lbm_redir, ltm_redir, raps_hit, gen_hit;
   logic lbm_da_fail, level_fail, any_enabled;
   logic rot_go;
   logic [2:0] new_class, new_ptr, cur_ptr;
   logic [1:0] cur_sel;
   logic [4:0] cur_ena;
   logic [1:0] ptr_idx;

   assign cur_sel = outer_vid_match_select[frm_entry];
   assign cur_ena = ena[frm_entry];
   assign remaining = 3'({1'b0, frm_tags_in}) + 3'({1'b0, frm_pushed})
                      - 3'({1'b0, frm_popped});
   assign single_tag = remaining == `ONE_TAG && frm_tag_known; // [R21]
   assign untagged = remaining == `NO_TAGS;

   always_comb begin
      unique case (cur_sel)
         `SEL_ANY: vid_ok = 1'b1; // [R1]
         `SEL_UNTAGGED: vid_ok = untagged; // [R1]
         `SEL_SINGLE: vid_ok = single_tag && // [R2]
                               frm_vid == required_outer_vid[frm_entry];
         `SEL_BOTH: vid_ok = untagged || (single_tag && // [R3]
                               frm_vid == required_outer_vid[frm_entry]);
      endcase
   end

   assign active = frm_valid && frm_entry != '0 && vid_ok &&
                   frm_pdu != oam_mip_pkg::PDU_OTHER;
   assign level_ok = frm_level == level[frm_entry];
   assign da_check_off = da_hi[frm_entry] == '0 &&
                         da_lo[frm_entry] == '0; // [R4]
   assign da_ok = da_check_off ||
                  frm_da == {da_hi[frm_entry], da_lo[frm_entry]}; // [R4]

   always_comb begin
      unique case (frm_pdu)
         oam_mip_pkg::PDU_CCM:
            any_enabled = cur_ena[`ENA_CCM] || copy_once[frm_entry];
         oam_mip_pkg::PDU_LBM: any_enabled = cur_ena[`ENA_LBM];
         oam_mip_pkg::PDU_LTM: any_enabled = cur_ena[`ENA_LTM];
         oam_mip_pkg::PDU_RAPS: any_enabled = cur_ena[`ENA_RAPS];
         oam_mip_pkg::PDU_GENERIC: any_enabled = cur_ena[`ENA_GEN] &&
                                   frm_opcode == gen_op[frm_entry];
         default: any_enabled = 1'b0;
      endcase
   end

   assign level_fail = active && any_enabled && !level_ok; // [R9]
   assign ccm_copy = active && level_ok && any_enabled &&
                     frm_pdu == oam_mip_pkg::PDU_CCM; // [R10]
   assign lbm_redir = active && level_ok && any_enabled && da_ok &&
                      frm_pdu == oam_mip_pkg::PDU_LBM;
   assign lbm_da_fail = active && level_ok && any_enabled && !da_ok &&
                        frm_pdu == oam_mip_pkg::PDU_LBM; // [R8]
   assign ltm_redir = active && level_ok && any_enabled &&
                      frm_pdu == oam_mip_pkg::PDU_LTM;
   assign raps_hit = active && level_ok && any_enabled &&
                     frm_pdu == oam_mip_pkg::PDU_RAPS;
   assign gen_hit = active && level_ok && any_enabled &&
                    frm_pdu == oam_mip_pkg::PDU_GENERIC;

   // Class rotation
   assign ptr_idx = frm_nxt_sel - 2'h1;
   assign cur_ptr = cos_ptr[frm_isdx][ptr_idx];
   assign rot_go = frm_valid && // [R15]
                   frm_timestamp_mode_field == oam_mip_pkg::TS_INJECT_LOOPBACK &&
                   frm_nxt_sel != 2'h0 && frm_isdx != '0 &&
                   frm_class_mask != '0; // [R13]
   assign new_class = pick_offset(frm_class_mask, cur_ptr); // [R16]
   assign new_ptr = 3'(new_class + `ONE_CLASS); // [R17]

   // Edited descriptor
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_valid <= 1'b0;
         out_mip_hit <= 1'b0;
         out_copy_cpu <= 1'b0;
         out_redirect_cpu <= 1'b0;
         out_class <= `ZERO_CLASS;
         out_outer_prio <= `ZERO_CLASS;
         out_tc <= `ZERO_CLASS;
         out_stack_prio <= `ZERO_CLASS;
         out_nxt_sel <= 2'h0;
      end else begin
         out_valid <= frm_valid;
         out_mip_hit <= active;
         out_copy_cpu <= ccm_copy;
         out_redirect_cpu <= lbm_redir || ltm_redir || raps_hit || gen_hit;
         out_class <= frm_class;
         out_outer_prio <= frm_outer_prio;
         out_tc <= frm_tc;
         out_stack_prio <= frm_stack_prio;
         out_nxt_sel <= frm_nxt_sel;
         if (rot_go) begin
            if (frm_write_class_en) out_class <= new_class; // [R14]
            if (frm_write_tc_en) out_tc <= new_class; // [R14]
            if (frm_write_stack_prio_en) out_stack_prio <= new_class; // [R14]
            // Outer tag is left to normal tagging on down-facing frames
            if (frm_write_outer_prio_en && frm_up_mep) begin
               out_outer_prio <= new_class; // [R18] [R20]
            end
            // Stops a second rotation when the looped frame returns
            if (frm_up_mep) out_nxt_sel <= 2'h0; // [R19]
         end
      end
   end

   // Software-owned entry table
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int e = 0; e < ENTRIES; e++) begin
            required_outer_vid[e] <= '0;
            outer_vid_match_select[e] <= `SEL_ANY;
            da_hi[e] <= '0;
            da_lo[e] <= '0;
            level[e] <= '0;
            ena[e] <= '0;
            gen_op[e] <= '0;
            interval[e] <= '0;
         end
      end else begin
         if (wr_hit(`ADDR_VID_CTRL)) begin
            required_outer_vid[entry_sel] <= reg_wdata[`VID_MSB:0];
            outer_vid_match_select[entry_sel] <= reg_wdata[`SEL_MSB:`SEL_LSB];
         end
         if (wr_hit(`ADDR_DA_UPPER)) da_hi[entry_sel] <= reg_wdata[15:0];
         if (wr_hit(`ADDR_DA_LOWER)) da_lo[entry_sel] <= reg_wdata;
         if (wr_hit(`ADDR_ENTRY_CFG)) begin
            level[entry_sel] <= reg_wdata[`CFG_LEVEL_MSB:0];
            ena[entry_sel] <= reg_wdata[`CFG_ENA_MSB:`CFG_ENA_LSB];
            gen_op[entry_sel] <= reg_wdata[`CFG_OP_MSB:`CFG_OP_LSB];
         end
         if (wr_hit(`ADDR_COPY_ONCE)) begin
            interval[entry_sel] <= reg_wdata[`CO_INTERVAL_MSB:0];
         end
      end
   end

   // Copy-once bits: arm-all and software set win over a frame's clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         copy_once <= '0;
      end else begin
         if (ccm_copy) copy_once[frm_entry] <= 1'b0; // [R10]
         if (wr_hit(`ADDR_COPY_ONCE)) begin
            copy_once[entry_sel] <= reg_wdata[`CO_BIT];
         end
         if (wr_hit(`ADDR_GLOBAL) && reg_wdata[`GL_ARM_BIT]) begin
            for (int e = 0; e < ENTRIES; e++) begin
               if (interval_mask[interval[e]]) copy_once[e] <= 1'b1; // [R11]
            end
         end
      end
   end

   // Globals and selects
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         entry_sel <= '0;
         isdx_sel <= '0;
         interval_mask <= '0;
      end else begin
         if (wr_hit(`ADDR_ENTRY_SEL)) entry_sel <= reg_wdata[EW-1:0];
         if (wr_hit(`ADDR_ISDX_SEL)) isdx_sel <= reg_wdata[IW-1:0];
         if (wr_hit(`ADDR_GLOBAL)) begin
            interval_mask <= reg_wdata[`GL_MASK_MSB:`GL_MASK_LSB]; // [R11]
         end
      end
   end

   // Sticky events, set beats a same-cycle clear
   logic [`EV_COUNT-1:0] ev_set;
   assign ev_set = {level_fail, lbm_da_fail, gen_hit, raps_hit,
                    ltm_redir, lbm_redir, ccm_copy}; // [R5] [R6] [R7]
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         events <= '0;
      end else begin
         events <= (events & ~(wr_hit(`ADDR_EVENTS) ?
                    reg_wdata[`EV_COUNT-1:0] : '0)) | ev_set; // [R22]
      end
   end

   // Rotation pointers; a frame write-back beats a software write
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int s = 0; s < ISDX_COUNT; s++) begin
            for (int p = 0; p < 3; p++) cos_ptr[s][p] <= '0;
         end
      end else begin
         if (wr_hit(`ADDR_ROT_PTRS)) begin
            for (int p = 0; p < 3; p++) begin
               cos_ptr[isdx_sel][p] <=
                  reg_wdata[p*`PTR_FIELD_STRIDE +: 3];
            end
         end
         if (rot_go) cos_ptr[frm_isdx][ptr_idx] <= new_ptr; // [R17]
      end
   end

   // Read port: data only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= `RD_ZERO;
      end else begin
         reg_rdata <= `RD_ZERO;
         if (reg_rd) begin
            unique case (reg_addr)
               `ADDR_ENTRY_SEL: reg_rdata <= 32'(entry_sel);
               `ADDR_VID_CTRL:
                  reg_rdata <= 32'({outer_vid_match_select[entry_sel], required_outer_vid[entry_sel]});
               `ADDR_DA_UPPER: reg_rdata <= 32'(da_hi[entry_sel]);
               `ADDR_DA_LOWER: reg_rdata <= da_lo[entry_sel];
               `ADDR_ENTRY_CFG: reg_rdata <= 32'({gen_op[entry_sel],
                                  ena[entry_sel], level[entry_sel]});
               `ADDR_COPY_ONCE: reg_rdata <= 32'({copy_once[entry_sel],
                                  interval[entry_sel]});
               `ADDR_GLOBAL: reg_rdata <= 32'({interval_mask, 4'h0});
               `ADDR_EVENTS: reg_rdata <= 32'(events);
               `ADDR_ISDX_SEL: reg_rdata <= 32'(isdx_sel);
               `ADDR_ROT_PTRS: reg_rdata <= 32'({1'b0, cos_ptr[isdx_sel][2],
                                  1'b0, cos_ptr[isdx_sel][1],
                                  1'b0, cos_ptr[isdx_sel][0]});
               default: reg_rdata <= `RD_ZERO;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_untagged_only;
      frm_valid && cur_sel == `SEL_UNTAGGED && !untagged |=> !out_mip_hit;
   endproperty
   a_untagged_only: assert property (p_untagged_only) // [R1]
      else $error("tagged frame accepted by untagged-only entry");

   property p_single_rejects_untagged;
      frm_valid && cur_sel == `SEL_SINGLE && untagged |=> !out_mip_hit;
   endproperty
   a_single_rejects_untagged: assert property (p_single_rejects_untagged) // [R2]
      else $error("untagged frame accepted by single-tag entry");

   property p_both_rejects_multi;
      frm_valid && cur_sel == `SEL_BOTH && remaining > `ONE_TAG
         |=> !out_mip_hit;
   endproperty
   a_both_rejects_multi: assert property (p_both_rejects_multi) // [R3]
      else $error("multi-tagged frame accepted");

   property p_da_fail_flag;
      lbm_da_fail |=> events[`EV_DA_FAIL] && !out_redirect_cpu;
   endproperty
   a_da_fail_flag: assert property (p_da_fail_flag) // [R8]
      else $error("loopback address failure not flagged");

   sequence s_copy_once_hit;
      ccm_copy && !cur_ena[`ENA_CCM] && !reg_wr;
   endsequence
   sequence s_copy_done;
      out_copy_cpu && events[`EV_CCM];
   endsequence
   property p_copy_once;
      s_copy_once_hit |=> s_copy_done ##0 !copy_once[$past(frm_entry)];
   endproperty
   a_copy_once: assert property (p_copy_once) // [R10] [R5]
      else $error("copy-once did not copy and clear");

   property p_sticky_holds;
      events[`EV_LTM] && !(wr_hit(`ADDR_EVENTS) && reg_wdata[`EV_LTM])
         |=> events[`EV_LTM];
   endproperty
   a_sticky_holds: assert property (p_sticky_holds) // [R22]
      else $error("sticky flag dropped without clear");

   property p_rot_writeback;
      rot_go && !wr_hit(`ADDR_ROT_PTRS)
         |=> cos_ptr[$past(frm_isdx)][$past(ptr_idx)] == $past(new_ptr);
   endproperty
   a_rot_writeback: assert property (p_rot_writeback) // [R17]
      else $error("pointer write-back wrong");

   property p_up_zero_sel;
      rot_go && frm_up_mep |=> out_nxt_sel == 2'h0;
   endproperty
   a_up_zero_sel: assert property (p_up_zero_sel) // [R19]
      else $error("selector not cleared on up-facing pass");

   property p_down_outer_kept;
      frm_valid && !frm_up_mep |=> out_outer_prio == $past(frm_outer_prio);
   endproperty
   a_down_outer_kept: assert property (p_down_outer_kept) // [R20]
      else $error("outer priority changed on down-facing frame");

   property p_no_rot_keeps_class;
      frm_valid && frm_class_mask == '0 |=> out_class == $past(frm_class);
   endproperty
   a_no_rot_keeps_class: assert property (p_no_rot_keeps_class) // [R15]
      else $error("class changed with empty mask");

endmodule // oam_mip_filter_cos_update
`default_nettype wire

// [tb/oam_mip_filter_cos_update_tb_top.sv]
// Self-checking bench for the OAM filter and class rotation block
`timescale 1ns/10ps
`default_nettype none
module oam_mip_filter_cos_update_tb_top;
   logic sys_clk, sys_rst, reg_wr, reg_rd;
   logic [7:0] reg_addr, frm_opcode, frm_class_mask;
   logic [31:0] reg_wdata, reg_rdata;
   logic frm_valid, frm_tag_known, frm_up_mep, frm_write_class_en;
   logic frm_write_outer_prio_en, frm_write_tc_en, frm_write_stack_prio_en;
   logic [2:0] frm_entry, frm_level, frm_class, frm_outer_prio, frm_tc;
   logic [2:0] frm_stack_prio, out_class, out_outer_prio, out_tc;
   logic [2:0] out_stack_prio;
   logic [47:0] frm_da;
   logic [1:0] frm_tags_in, frm_popped, frm_pushed, frm_nxt_sel, out_nxt_sel;
   logic [11:0] frm_vid;
   logic [3:0] frm_isdx;
   oam_mip_pkg::pdu_kind_type frm_pdu;
   oam_mip_pkg::timestamp_mode_field_type frm_timestamp_mode_field;
   logic out_valid, out_mip_hit, out_copy_cpu, out_redirect_cpu;
   int err_count;
   int compares;

   oam_mip_frame_src #(.EW(3), .IW(4)) src (.*);

   oam_mip_filter_cos_update #(.ENTRIES(8), .ISDX_COUNT(16)) uut (.*);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk_bit(input logic got, input logic exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk_val(reg_rdata, e, m);
   endtask

   task automatic wrap_up;
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // First set mask bit at (offset + pointer) mod 8 gives the offset
   function automatic logic [2:0] scan(input logic [7:0] m,
         input logic [2:0] p);
      scan = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (m[(i + p) % 8]) begin
            scan = i[2:0];
         end
      end
   endfunction

   task automatic t_vid;
      logic [3:0] tab [4];
      tab = '{4'b1111, 4'b0001, 4'b0010, 4'b0011};
      wr(8'h00, 32'h0000_0001);
      wr(8'h10, 32'h0000_20FA);
      for (int s = 0; s < 4; s++) begin
         wr(8'h04, {18'h0, s[1:0], 12'h123});
         rd(8'h04, {18'h0, s[1:0], 12'h123}, "vid ctrl");
         for (int k = 0; k < 4; k++) begin
            // Kind 1 pops the only tag and pushes one back
            src.send(3'h1, oam_mip_pkg::PDU_LTM, 3'h2, 48'h0,
               (k == 0) ? 6'h00 : (k == 1) ? 6'h15 : (k == 2) ? 6'h10 : 6'h20,
               (k == 2) ? 12'h124 : 12'h123);
            chk_bit(out_mip_hit, tab[s][k], "vid filter");
         end
      end
      wr(8'h04, 32'h0000_0000);
      $display("vid filter test done");
   endtask

   task automatic ev_case(input oam_mip_pkg::pdu_kind_type p,
         input logic [2:0] l, input logic [47:0] d, input logic re,
         input logic ce);
      src.send(3'h1, p, l, d, 6'h10, 12'h123);
      chk_bit(out_valid, 1'b1, "valid");
      chk_bit(out_redirect_cpu, re, "redirect");
      chk_bit(out_copy_cpu, ce, "copy");
   endtask

   task automatic t_events;
      wr(8'h1C, 32'h0000_007F);
      rd(8'h1C, 32'h0000_0000, "events cleared");
      wr(8'h08, 32'h0000_0A0B);
      wr(8'h0C, 32'h0C0D_0E0F);
      ev_case(oam_mip_pkg::PDU_LBM, 3'h2, 48'h0A0B_0C0D_0E0F, 1, 0);
      ev_case(oam_mip_pkg::PDU_LBM, 3'h2, 48'h0A0B_0C0D_0E0E, 0, 0);
      ev_case(oam_mip_pkg::PDU_LTM, 3'h2, 48'h0, 1, 0);
      ev_case(oam_mip_pkg::PDU_RAPS, 3'h2, 48'h0, 1, 0);
      ev_case(oam_mip_pkg::PDU_GENERIC, 3'h2, 48'h0, 1, 0);
      ev_case(oam_mip_pkg::PDU_CCM, 3'h1, 48'h0, 0, 0);
      ev_case(oam_mip_pkg::PDU_CCM, 3'h2, 48'h0, 0, 1);
      rd(8'h1C, 32'h0000_007F, "events");
      wr(8'h1C, 32'h0000_0005);
      rd(8'h1C, 32'h0000_007A, "partial clear");
      wr(8'h08, 32'h0000_0000);
      wr(8'h0C, 32'h0000_0000);
      ev_case(oam_mip_pkg::PDU_LBM, 3'h2, 48'h1234_5678_9ABC, 1, 0);
      $display("event test done");
   endtask

   task automatic t_copy_once;
      wr(8'h00, 32'h0000_0002);
      wr(8'h10, 32'h0000_0000);
      wr(8'h14, 32'h0000_0004);
      src.send(3'h2, oam_mip_pkg::PDU_CCM, 3'h0, 48'h0, 6'h0, 12'h0);
      chk_bit(out_copy_cpu, 1'b1, "first copy");
      src.send(3'h2, oam_mip_pkg::PDU_CCM, 3'h0, 48'h0, 6'h0, 12'h0);
      chk_bit(out_copy_cpu, 1'b0, "second copy");
      rd(8'h14, 32'h0000_0000, "copy once cleared");
      wr(8'h18, 32'h0000_0010);
      wr(8'h18, 32'h0000_0011);
      rd(8'h14, 32'h0000_0004, "armed");
      wr(8'h14, 32'h0000_0001);
      wr(8'h18, 32'h0000_0011);
      rd(8'h14, 32'h0000_0001, "interval not armed");
      $display("copy once test done");
   endtask

   task automatic t_rotation;
      logic [2:0] cls, ptr;
      logic up;
      ptr = 3'h0;
      wr(8'h20, 32'h0000_0003);
      wr(8'h24, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         up = (i < 2);
         src.rot(4'h3, 2'h1, 8'h08, up);
         src.send(3'h0, oam_mip_pkg::PDU_CCM, 3'h0, 48'h0, 6'h0, 12'h0);
         cls = scan(8'h08, ptr);
         ptr = cls + 3'h1;
         chk_val(out_class, cls, "class");
         chk_val(out_tc, cls, "tc");
         chk_val(out_stack_prio, cls, "stack prio");
         chk_val(out_outer_prio, up ? cls : 3'h5, "outer prio");
         chk_val(out_nxt_sel, up ? 2'h0 : 2'h1, "selector");
         rd(8'h24, {29'h0, ptr}, "pointer");
      end
      for (int c = 0; c < 3; c++) begin
         src.rot((c == 1) ? 4'h0 : 4'h3, (c == 2) ? 2'h0 : 2'h1,
            (c == 0) ? 8'h00 : 8'h08, 1'b1);
         src.send(3'h0, oam_mip_pkg::PDU_CCM, 3'h0, 48'h0, 6'h0, 12'h0);
         chk_val(out_class, 3'h6, "class kept");
         rd(8'h24, {29'h0, ptr}, "pointer kept");
      end
      $display("rotation test done");
   endtask

   initial begin
      #200000;
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up;
   end

   initial begin
      err_count = 0;
      compares = 0;
      sys_rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h1C, 32'h0000_0000, "events at reset");
      rd(8'h3C, 32'h0000_0000, "unmapped");
      t_vid;
      t_events;
      t_copy_once;
      t_rotation;
      wrap_up;
   end
endmodule // oam_mip_filter_cos_update_tb_top
`default_nettype wire

// [tb/oam_mip_frame_src.sv]
// Forwarding pipeline model that hands frame descriptors to the filter
`timescale 1ns/10ps
`default_nettype none
module oam_mip_frame_src #(
   parameter int EW = 3,
   parameter int IW = 4
) (
   // Clock
   input wire logic sys_clk,
   // Filter descriptor
   output logic frm_valid,
   output logic [EW-1:0] frm_entry,
   output var oam_mip_pkg::pdu_kind_type frm_pdu,
   output logic [7:0] frm_opcode,
   output logic [2:0] frm_level,
   output logic [47:0] frm_da,
   output logic [1:0] frm_tags_in,
   output logic [1:0] frm_popped,
   output logic [1:0] frm_pushed,
   output logic frm_tag_known,
   output logic [11:0] frm_vid,
   // Injector rotation fields
   output var oam_mip_pkg::timestamp_mode_field_type frm_timestamp_mode_field,
   output logic [IW-1:0] frm_isdx,
   output logic [1:0] frm_nxt_sel,
   output logic [7:0] frm_class_mask,
   output logic frm_write_class_en,
   output logic frm_write_outer_prio_en,
   output logic frm_write_tc_en,
   output logic frm_write_stack_prio_en,
   output logic frm_up_mep,
   output logic [2:0] frm_class,
   output logic [2:0] frm_outer_prio,
   output logic [2:0] frm_tc,
   output logic [2:0] frm_stack_prio
);
   initial begin
      {frm_valid, frm_entry, frm_opcode, frm_level, frm_da} = '0;
      {frm_tags_in, frm_popped, frm_pushed, frm_vid} = '0;
      {frm_isdx, frm_nxt_sel, frm_class_mask, frm_up_mep} = '0;
      frm_pdu = oam_mip_pkg::PDU_OTHER;
      frm_timestamp_mode_field = oam_mip_pkg::TS_NONE;
      frm_tag_known = 1'b1;
      frm_write_class_en = 1'b1;
      frm_write_outer_prio_en = 1'b1;
      frm_write_tc_en = 1'b1;
      frm_write_stack_prio_en = 1'b1;
      frm_class = 3'h6;
      frm_outer_prio = 3'h5;
      frm_tc = 3'h4;
      frm_stack_prio = 3'h2;
   end

   task automatic rot(input logic [IW-1:0] i, input logic [1:0] s,
         input logic [7:0] m, input logic up);
      @(posedge sys_clk);
      frm_isdx <= i;
      frm_nxt_sel <= s;
      frm_timestamp_mode_field <= (s != 2'h0) ? oam_mip_pkg::TS_INJECT_LOOPBACK
                                 : oam_mip_pkg::TS_NONE;
      frm_class_mask <= m;
      frm_up_mep <= up;
   endtask

   task automatic send(input logic [EW-1:0] e,
         input oam_mip_pkg::pdu_kind_type p, input logic [2:0] l,
         input logic [47:0] d, input logic [5:0] t, input logic [11:0] v);
      @(posedge sys_clk);
      frm_valid <= 1'b1;
      frm_entry <= e;
      frm_pdu <= p;
      frm_opcode <= (p == oam_mip_pkg::PDU_GENERIC) ? 8'h20 : 8'h01;
      frm_level <= l;
      frm_da <= d;
      {frm_tags_in, frm_popped, frm_pushed} <= t;
      frm_vid <= v;
      @(posedge sys_clk);
      frm_valid <= 1'b0;
      // Stale fields must not look like a live frame
      frm_da <= ~d;
      frm_vid <= ~v;
      #1;
   endtask
endmodule // oam_mip_frame_src
`default_nettype wire
